/* File: design/alu_ops_pkg.sv */
// shared constants, types and operation codes for the alu datapath block
package alu_ops_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int BIT_W = 3;
   localparam int CARRY_BIT = 8;
   localparam int HALF_BIT = 4;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic DEST_ACC = 1'h0;
   localparam logic DEST_REG = 1'h1;
   // file register addresses with side effects; arbitrary defaults
   localparam logic [ADDR_W-1:0] TIMER_ZERO_ADDR = 7'h01;
   localparam logic [ADDR_W-1:0] PORT_ADDR = 7'h05;

   typedef enum logic [3:0] {
      OP_NOP = 4'h0,
      OP_ADD_LIT = 4'h1,
      OP_ADD_REG = 4'h2,
      OP_AND_LIT = 4'h3,
      OP_AND_REG = 4'h4,
      OP_BIT_CLR = 4'h5,
      OP_BIT_SET = 4'h6,
      OP_SKIP_ONE = 4'h7,
      OP_SKIP_ZERO = 4'h8
   } alu_op_t;

   typedef enum logic [0:0] {
      ST_RUN = 1'b0,
      ST_SKIP = 1'b1
   } exec_state_t;
endpackage : alu_ops_pkg

/* File: design/file_port_if.sv */
// signals between the execution core and its result/flag unit
`timescale 1ns/100ps
interface file_port_if;
   import alu_ops_pkg::*;
   alu_op_t op;
   logic [DATA_W-1:0] acc;
   logic [DATA_W-1:0] operand;
   logic [BIT_W-1:0] bit_sel;
   logic [DATA_W-1:0] result;
   logic carry;
   logic half_carry;
   logic zero;
   logic bit_val;
   modport core (output op, acc, operand, bit_sel, input result, carry, half_carry, zero, bit_val);
   modport unit (input op, acc, operand, bit_sel, output result, carry, half_carry, zero, bit_val);
endinterface : file_port_if

/* File: design/alu_result_unit.sv */
// combinational result and flag generation
`timescale 1ns/100ps
module alu_result_unit
   import alu_ops_pkg::*;
(
   file_port_if.unit fp
);
   function automatic logic [DATA_W-1:0] bit_mask(input logic [BIT_W-1:0] idx);
      bit_mask = 8'h01 << idx;
   endfunction : bit_mask

   logic [CARRY_BIT:0] sum;
   logic [HALF_BIT:0] half_sum;

   always_comb begin
      sum = {1'b0, fp.acc} + {1'b0, fp.operand};
      half_sum = {1'b0, fp.acc[HALF_BIT-1:0]} + {1'b0, fp.operand[HALF_BIT-1:0]};
      fp.bit_val = |(fp.operand & bit_mask(fp.bit_sel));
      case (fp.op)
         // RULE_01 literal sum
         OP_ADD_LIT, OP_ADD_REG: begin
            fp.result = sum[DATA_W-1:0];
         end
         // RULE_04 literal and
         OP_AND_LIT, OP_AND_REG: begin
            fp.result = fp.acc & fp.operand;
         end
         // RULE_06 clear one bit
         OP_BIT_CLR: begin
            fp.result = fp.operand & ~bit_mask(fp.bit_sel);
         end
         // RULE_07 set one bit
         OP_BIT_SET: begin
            fp.result = fp.operand | bit_mask(fp.bit_sel);
         end
         default: begin
            fp.result = fp.operand;
         end
      endcase
      // RULE_12 flag sources
      fp.carry = sum[CARRY_BIT];
      fp.half_carry = half_sum[HALF_BIT];
      fp.zero = (fp.result == ZERO_BYTE);
   end
endmodule : alu_result_unit

/* File: design/alu_bit_skip_core.sv */
// execution core for add, and, bit set/clear and bit test/skip operations
`timescale 1ns/100ps
// Summary of operation
// RULE_01 - add literal to accumulator, update c dc z
// RULE_02 - add file register to accumulator, flags updated
// RULE_03 - destination bit: 0 accumulator, 1 register
// RULE_04 - and literal into accumulator, zero only
// RULE_05 - and file register, routed, zero only
// RULE_06 - clear selected bit, flags untouched
// RULE_07 - set selected bit, flags untouched
// RULE_08 - skip next when tested bit is one
// RULE_09 - skip next when tested bit is zero
// RULE_10 - port reads use pin levels
// RULE_11 - timer zero write clears prescaler
// RULE_12 - carry bit7, half bit3, zero result
module alu_bit_skip_core
   import alu_ops_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire alu_op_t instr_op,
   input wire logic [DATA_W-1:0] literal,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [BIT_W-1:0] bit_sel,
   input wire logic dest_sel,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic [DATA_W-1:0] port_pins,
   input wire logic prescaler_on_timer,
   output logic [DATA_W-1:0] acc_out,
   output logic carry_flag,
   output logic half_carry_flag,
   output logic zero_flag,
   output logic reg_we,
   output logic [ADDR_W-1:0] reg_waddr,
   output logic [DATA_W-1:0] reg_wdata,
   output logic skip_active,
   output logic prescaler_clr,
   output logic instr_done
);
   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      exec_state_t st;
      logic [DATA_W-1:0] acc;
      logic c;
      logic dc;
      logic z;
      logic we;
      logic [ADDR_W-1:0] waddr;
      logic [DATA_W-1:0] wdata;
      logic pclr;
      logic done;
   } core_state_t;

   core_state_t s_reg;
   core_state_t s_next;
   logic [DATA_W-1:0] src;
   logic writes_reg;
   logic is_lit;

   file_port_if fp ();

   alu_result_unit u_result (
      .fp(fp)
   );

   // ****************************************
   // decode helpers
   // ****************************************
   // only a clear destination bit keeps a register-source result in the accumulator
   function automatic logic to_acc(input logic dsel);
      to_acc = (dsel == DEST_ACC);
   endfunction : to_acc

   // side-effect addresses match on all address bits, so no alias can trigger them
   function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] target);
      addr_is = (addr == target);
   endfunction : addr_is

   // literal ops never read the file, so a port address in their operand field is harmless
   function automatic logic is_literal_op(input alu_op_t op);
      case (op)
         OP_ADD_LIT, OP_AND_LIT: begin
            is_literal_op = 1'b1;
         end
         default: begin
            is_literal_op = 1'b0;
         end
      endcase
   endfunction : is_literal_op

   // ****************************************
   // operand selection
   // ****************************************
   always_comb begin
      is_lit = is_literal_op(instr_op);
      // RULE_10 pins, not latch
      if (addr_is(reg_addr, PORT_ADDR)) begin
         src = port_pins;
      end else begin
         src = reg_rdata;
      end
      fp.op = instr_op;
      fp.acc = s_reg.acc;
      fp.operand = is_lit ? literal : src;
      fp.bit_sel = bit_sel;
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s_next = s_reg;
      // pulses last one cycle; acc, flags and state hold unless an op changes them
      s_next.we = 1'b0;
      s_next.pclr = 1'b0;
      s_next.done = 1'b0;
      writes_reg = 1'b0;
      case (s_reg.st)
         ST_RUN: begin
            if (instr_valid) begin
               s_next.done = 1'b1;
               case (instr_op)
                  // RULE_01 literal add into accumulator
                  OP_ADD_LIT: begin
                     s_next.acc = fp.result;
                     s_next.c = fp.carry;
                     s_next.dc = fp.half_carry;
                     s_next.z = fp.zero;
                  end
                  // RULE_02 register add with flags
                  OP_ADD_REG: begin
                     s_next.c = fp.carry;
                     s_next.dc = fp.half_carry;
                     s_next.z = fp.zero;
                     // RULE_03 destination routing
                     if (to_acc(dest_sel)) begin
                        s_next.acc = fp.result;
                     end else begin
                        writes_reg = 1'b1;
                     end
                  end
                  // RULE_04 zero flag only
                  OP_AND_LIT: begin
                     s_next.acc = fp.result;
                     s_next.z = fp.zero;
                  end
                  // RULE_05 routed and, zero only
                  OP_AND_REG: begin
                     s_next.z = fp.zero;
                     if (to_acc(dest_sel)) begin
                        s_next.acc = fp.result;
                     end else begin
                        writes_reg = 1'b1;
                     end
                  end
                  // RULE_06 RULE_07 write back, no flags
                  OP_BIT_CLR, OP_BIT_SET: begin
                     writes_reg = 1'b1;
                  end
                  // RULE_08 skip on one
                  OP_SKIP_ONE: begin
                     if (fp.bit_val) begin
                        s_next.st = ST_SKIP;
                     end
                  end
                  // RULE_09 skip on zero
                  OP_SKIP_ZERO: begin
                     if (!fp.bit_val) begin
                        s_next.st = ST_SKIP;
                     end
                  end
                  default: begin
                  end
               endcase
               if (writes_reg) begin
                  s_next.we = 1'b1;
                  s_next.waddr = reg_addr;
                  s_next.wdata = fp.result;
                  // RULE_11 timer write clears prescaler
                  s_next.pclr = addr_is(reg_addr, TIMER_ZERO_ADDR) && prescaler_on_timer;
               end
            end
         end
         // discarded instruction runs as a nop; nothing is committed
         // a skip stays pending across idle cycles until the next real instruction
         ST_SKIP: begin
            if (instr_valid) begin
               s_next.st = ST_RUN;
               s_next.done = 1'b1;
            end
         end
         default: begin
            s_next.st = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '{st: ST_RUN, acc: ACC_RESET, waddr: '0, wdata: ZERO_BYTE, default: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // every output is a state field, so no input reaches a pin combinationally
   assign acc_out = s_reg.acc;
   assign carry_flag = s_reg.c;
   assign half_carry_flag = s_reg.dc;
   assign zero_flag = s_reg.z;
   assign reg_we = s_reg.we;
   assign reg_waddr = s_reg.waddr;
   assign reg_wdata = s_reg.wdata;
   assign skip_active = (s_reg.st == ST_SKIP);
   assign prescaler_clr = s_reg.pclr;
   assign instr_done = s_reg.done;
endmodule : alu_bit_skip_core

/* File: tb/alu_core_properties.sv */
// port checker for the alu bit and skip core
`timescale 1ns/100ps
module alu_core_properties
   import alu_ops_pkg::*;
(
   input logic ref_clk,
   input logic rst_n,
   input logic instr_valid,
   input alu_op_t instr_op,
   input logic [7:0] literal,
   input logic [6:0] reg_addr,
   input logic [2:0] bit_sel,
   input logic dest_sel,
   input logic [7:0] reg_rdata,
   input logic [7:0] acc_out,
   input logic carry_flag,
   input logic half_carry_flag,
   input logic zero_flag,
   input logic reg_we,
   input logic [6:0] reg_waddr,
   input logic [7:0] reg_wdata,
   input logic skip_active,
   input logic prescaler_clr,
   input logic instr_done
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic go;
   logic own;
   assign go = instr_valid && !skip_active;
   // port reads use pins, so operand checks skip that address
   assign own = go && reg_addr != PORT_ADDR;
   a_add_sum: assert property (go && instr_op == OP_ADD_LIT |=> acc_out == 8'($past(acc_out) + $past(literal)))
      else $error("add literal sum wrong");
   a_carry_out: assert property (go && instr_op == OP_ADD_LIT |=>
      carry_flag == ({1'b0, $past(acc_out)} + $past(literal) > 9'h0ff)) else $error("carry out wrong");
   a_half_carry: assert property (go && instr_op == OP_ADD_LIT |=>
      half_carry_flag == ({1'b0, $past(acc_out[3:0])} + $past(literal[3:0]) > 5'h0f)) else $error("half carry wrong");
   a_and_write: assert property (own && instr_op == OP_AND_REG && dest_sel |=>
      reg_we && reg_wdata == ($past(acc_out) & $past(reg_rdata)) && $stable(carry_flag)) else $error("and write wrong");
   a_dest_acc: assert property (go && instr_op inside {OP_ADD_REG, OP_AND_REG} && !dest_sel |=> !reg_we)
      else $error("write with accumulator destination");
   a_and_flags: assert property (go && instr_op == OP_AND_LIT |=>
      $stable(carry_flag) && zero_flag == (acc_out == 8'h00)) else $error("and flags wrong");
   a_clr_bit: assert property (own && instr_op == OP_BIT_CLR |=>
      reg_we && reg_wdata == ($past(reg_rdata) & ~(8'h01 << $past(bit_sel)))) else $error("bit clear wrong");
   a_set_bit: assert property (own && instr_op == OP_BIT_SET |=>
      reg_we && reg_wdata == ($past(reg_rdata) | (8'h01 << $past(bit_sel)))) else $error("bit set wrong");
   a_skip_sense: assert property (own && instr_op inside {OP_SKIP_ONE, OP_SKIP_ZERO} |=>
      skip_active == $past(reg_rdata[bit_sel] ^ (instr_op == OP_SKIP_ZERO))) else $error("skip decision wrong");
   a_skip_nop: assert property (instr_valid && skip_active |=>
      instr_done && !reg_we && !skip_active && $stable(acc_out)) else $error("discarded instruction acted");
   a_presc_clr: assert property (prescaler_clr |-> reg_we && reg_waddr == TIMER_ZERO_ADDR)
      else $error("prescaler clear without timer write");
endmodule : alu_core_properties

bind alu_bit_skip_core alu_core_properties alu_core_properties_i (
   .ref_clk(ref_clk),
   .rst_n(rst_n),
   .instr_valid(instr_valid),
   .instr_op(instr_op),
   .literal(literal),
   .reg_addr(reg_addr),
   .bit_sel(bit_sel),
   .dest_sel(dest_sel),
   .reg_rdata(reg_rdata),
   .acc_out(acc_out),
   .carry_flag(carry_flag),
   .half_carry_flag(half_carry_flag),
   .zero_flag(zero_flag),
   .reg_we(reg_we),
   .reg_waddr(reg_waddr),
   .reg_wdata(reg_wdata),
   .skip_active(skip_active),
   .prescaler_clr(prescaler_clr),
   .instr_done(instr_done)
);

/* File: tb/file_array_model.sv */
// file register array model with write forwarding
`timescale 1ns/100ps
module file_array_model (
   input logic ref_clk,
   input logic [6:0] reg_addr,
   input logic reg_we,
   input logic [6:0] reg_waddr,
   input logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata
);
   logic [7:0] mem [128];
   // each register powers up holding its own address
   initial for (int i = 0; i < 128; i++) mem[i] = 8'(i);
   // a write lands a cycle late, so the next read must see it already
   assign reg_rdata = (reg_we && reg_waddr == reg_addr) ? reg_wdata : mem[reg_addr];
   always @(posedge ref_clk) if (reg_we) mem[reg_waddr] <= reg_wdata;
endmodule : file_array_model

/* File: tb/mcu_alu_bit_skip_ops_bench.sv */
// self-checking bench for the alu bit and skip core
`timescale 1ns/100ps
module mcu_alu_bit_skip_ops_bench;
   import alu_ops_pkg::*;
   logic ref_clk = 0, rst_n = 0, instr_valid = 0, dest_sel = 0, prescaler_on_timer = 0;
   alu_op_t instr_op = OP_NOP;
   logic [7:0] literal = 8'h00, port_pins = 8'h40, reg_rdata, acc_out, reg_wdata;
   logic [6:0] reg_addr = 7'h00, reg_waddr;
   logic [2:0] bit_sel = 3'h0;
   logic carry_flag, half_carry_flag, zero_flag, reg_we, skip_active, prescaler_clr, instr_done;
   int n_errors = 0, n_tests = 0;
   alu_bit_skip_core alu_bit_skip_core_i (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .instr_valid(instr_valid),
      .instr_op(instr_op),
      .literal(literal),
      .reg_addr(reg_addr),
      .bit_sel(bit_sel),
      .dest_sel(dest_sel),
      .reg_rdata(reg_rdata),
      .port_pins(port_pins),
      .prescaler_on_timer(prescaler_on_timer),
      .acc_out(acc_out),
      .carry_flag(carry_flag),
      .half_carry_flag(half_carry_flag),
      .zero_flag(zero_flag),
      .reg_we(reg_we),
      .reg_waddr(reg_waddr),
      .reg_wdata(reg_wdata),
      .skip_active(skip_active),
      .prescaler_clr(prescaler_clr),
      .instr_done(instr_done)
   );
   file_array_model file_array_model_i (
      .ref_clk(ref_clk),
      .reg_addr(reg_addr),
      .reg_we(reg_we),
      .reg_waddr(reg_waddr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata)
   );
   initial forever #4 ref_clk = ~ref_clk;
   task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   function automatic logic [7:0] fl();
      return {5'h00, carry_flag, half_carry_flag, zero_flag};
   endfunction : fl
   // results of one instruction show while the next is presented
   task automatic ex(alu_op_t op, logic [7:0] v, logic [6:0] a = 7'h00, logic [2:0] b = 3'h0, logic d = 1'b0);
      @(posedge ref_clk);
      #1;
      instr_valid = 1;
      instr_op = op;
      literal = v;
      reg_addr = a;
      bit_sel = b;
      dest_sel = d;
   endtask : ex
   task automatic fin();
      @(posedge ref_clk);
      #1;
      instr_valid = 0;
   endtask : fin
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   // ****************
   // scenarios
   // ****************
   task automatic t_add();
      ex(OP_ADD_LIT, 8'h0f);
      ex(OP_ADD_LIT, 8'h01);
      chk("acc", acc_out, 8'h0f);
      ex(OP_ADD_LIT, 8'hf0);
      chk("flags", fl(), 8'h02);
      fin();
      chk("acc", acc_out, 8'h00);
      chk("flags", fl(), 8'h05);
      $display("t_add done");
   endtask : t_add
   task automatic t_reg();
      ex(OP_ADD_LIT, 8'hf1);
      ex(OP_ADD_REG, 8'h00, 7'h12, 3'h0, 1'b1);
      ex(OP_AND_REG, 8'h00, 7'h33, 3'h0, 1'b0);
      chk("wdata", reg_wdata, 8'h03);
      chk("waddr", {1'b0, reg_waddr}, 8'h12);
      chk("flags", fl(), 8'h04);
      chk("acc", acc_out, 8'hf1);
      ex(OP_AND_LIT, 8'h0e);
      chk("acc", acc_out, 8'h31);
      chk("we", {7'h00, reg_we}, 8'h00);
      fin();
      chk("acc", acc_out, 8'h00);
      chk("flags", fl(), 8'h05);
      $display("t_reg done");
   endtask : t_reg
   task automatic t_bits();
      ex(OP_BIT_CLR, 8'h00, 7'h37, 3'h1);
      ex(OP_BIT_SET, 8'h00, 7'h48, 3'h7);
      chk("wdata", reg_wdata, 8'h35);
      fin();
      chk("wdata", reg_wdata, 8'hc8);
      chk("flags", fl(), 8'h05);
      $display("t_bits done");
   endtask : t_bits
   task automatic t_skip();
      ex(OP_SKIP_ONE, 8'h00, 7'h03, 3'h1);
      ex(OP_ADD_LIT, 8'h01);
      chk("skip", {7'h00, skip_active}, 8'h01);
      ex(OP_SKIP_ZERO, 8'h00, 7'h03, 3'h2);
      chk("done", {7'h00, instr_done}, 8'h01);
      chk("acc", acc_out, 8'h00);
      ex(OP_ADD_LIT, 8'h01);
      chk("skip", {7'h00, skip_active}, 8'h01);
      ex(OP_SKIP_ONE, 8'h00, 7'h03, 3'h2);
      chk("acc", acc_out, 8'h00);
      ex(OP_SKIP_ZERO, 8'h00, 7'h03, 3'h0);
      chk("skip", {7'h00, skip_active}, 8'h00);
      ex(OP_ADD_LIT, 8'h02);
      chk("skip", {7'h00, skip_active}, 8'h00);
      fin();
      chk("acc", acc_out, 8'h02);
      $display("t_skip done");
   endtask : t_skip
   task automatic t_side();
      prescaler_on_timer = 1;
      ex(OP_BIT_SET, 8'h00, PORT_ADDR, 3'h0);
      ex(OP_BIT_CLR, 8'h00, TIMER_ZERO_ADDR, 3'h0);
      chk("wdata", reg_wdata, 8'h41);
      chk("clr", {7'h00, prescaler_clr}, 8'h00);
      fin();
      chk("wdata", reg_wdata, 8'h00);
      chk("clr", {7'h00, prescaler_clr}, 8'h01);
      $display("t_side done");
   endtask : t_side
   task automatic t_route();
      ex(OP_ADD_REG, 8'h00, 7'h7f, 3'h0, 1'b0);
      ex(OP_AND_REG, 8'h00, 7'h3c, 3'h0, 1'b1);
      chk("acc", acc_out, 8'h81);
      chk("we", {7'h00, reg_we}, 8'h00);
      chk("flags", fl(), 8'h02);
      ex(OP_ADD_REG, 8'h00, TIMER_ZERO_ADDR, 3'h0, 1'b0);
      chk("wdata", reg_wdata, 8'h00);
      chk("waddr", {1'b0, reg_waddr}, 8'h3c);
      chk("acc", acc_out, 8'h81);
      chk("flags", fl(), 8'h03);
      ex(OP_SKIP_ZERO, 8'h00, PORT_ADDR, 3'h0);
      chk("clr", {7'h00, prescaler_clr}, 8'h00);
      chk("we", {7'h00, reg_we}, 8'h00);
      chk("flags", fl(), 8'h00);
      prescaler_on_timer = 0;
      ex(OP_BIT_SET, 8'h00, TIMER_ZERO_ADDR, 3'h4);
      chk("skip", {7'h00, skip_active}, 8'h01);
      ex(OP_BIT_SET, 8'h00, TIMER_ZERO_ADDR, 3'h4);
      chk("we", {7'h00, reg_we}, 8'h00);
      chk("done", {7'h00, instr_done}, 8'h01);
      fin();
      chk("wdata", reg_wdata, 8'h10);
      chk("clr", {7'h00, prescaler_clr}, 8'h00);
      chk("we", {7'h00, reg_we}, 8'h01);
      $display("t_route done");
   endtask : t_route
   initial begin
      repeat (4) @(posedge ref_clk);
      #1;
      rst_n = 1;
      chk("acc", acc_out, 8'h00);
      t_add();
      t_reg();
      t_bits();
      t_skip();
      t_side();
      t_route();
      stop_test();
   end
   initial begin
      repeat (2000) @(posedge ref_clk);
      n_errors++;
      stop_test();
   end
endmodule : mcu_alu_bit_skip_ops_bench
